// >>> hdl/sac_consts.svh
// Timing counts, gain codes and reset values for the speaker output control.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
// ----------------------------------------
// Gain codes, half-dB units, signed
// ----------------------------------------
`define SAC_GAIN_FIXED     8'shf9
`define SAC_GAIN_START     8'shfc
`define SAC_GAIN_LIM_STEP  8'sh01
`define SAC_GAIN_REC_STEP  8'sh02
`define SAC_GAIN_FLOOR     8'sh80
// ----------------------------------------
// Periods in fs ticks
// ----------------------------------------
`define SAC_LIM_PERIOD_FS  10'h002
`define SAC_REC_PERIOD_FS0 10'h200
`define SAC_REC_PERIOD_FS1 10'h100
`define SAC_INIT_FS0       10'h200
`define SAC_INIT_FS1       10'h100
`define SAC_CNT_RESET      10'h000
`endif

// >>> hdl/sac_output_ctrl.sv
// Speaker and line output control with speaker level control.
`timescale 1ns/10ps
`include "sac_consts.svh"
module sac_output_ctrl (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               fs_tick_pin,
    input  wire sac_pkg::sac_ctrl_t ctrl,
    input  wire sac_pkg::sac_level_t level,
    output logic                    beep_stage_en,
    output logic                    beep_to_spk_path,
    output logic                    beep_to_line_path,
    output logic [1:0]              spk_gain_sel,
    output logic                    dac_to_line_path,
    output logic                    line_amp_en,
    output logic                    line_pulldown_en,
    output logic                    line_soft_ramp,
    output logic                    spk_block_en,
    output logic                    mixer_out_oe_n,
    output logic                    speaker_pos_oe_n,
    output logic                    speaker_neg_oe_n,
    output logic                    speaker_neg_half,
    output logic signed [7:0]       alc_gain,
    output logic                    alc_init_busy
);
    import sac_pkg::*;

    // ----------------------------------------
    // Static paths and power states
    // ----------------------------------------
    always_comb begin
        beep_stage_en     = ctrl.beep_power_on;
        // Routing follows the select bits alone, even with the stage down.
        beep_to_spk_path  = ctrl.beep_to_speaker_sel;
        beep_to_line_path = ctrl.beep_to_line_sel;
        spk_gain_sel      = ctrl.speaker_gain_field;
        dac_to_line_path  = ctrl.dac_to_line_sw &
                            ctrl.line_out_power_on;
        line_amp_en       = ctrl.line_out_power_on &
                            !ctrl.line_power_save;
        line_pulldown_en  = !ctrl.line_out_power_on &
                            !ctrl.line_power_save;
        // Save mode ramps slowly; the host owns the settle wait.
        line_soft_ramp    = ctrl.line_power_save;
        spk_block_en      = ctrl.speaker_block_power_on;
        mixer_out_oe_n    = !ctrl.speaker_block_power_on;
        speaker_pos_oe_n  = !(ctrl.speaker_block_power_on &
                              ctrl.speaker_save_mode_n);
        speaker_neg_oe_n  = !ctrl.speaker_block_power_on;
        speaker_neg_half  = ctrl.speaker_block_power_on &
                            !ctrl.speaker_save_mode_n;
    end

    // ----------------------------------------
    // Sample-rate tick synchroniser
    // ----------------------------------------
    logic [2:0] tick_sync_reg;
    logic [2:0] tick_sync_next;
    logic       fs_pulse;
    always_comb begin
        tick_sync_next = {tick_sync_reg[1:0], fs_tick_pin};
        fs_pulse       = tick_sync_reg[1] & !tick_sync_reg[2];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_sync_reg <= 3'h0;
        end else begin
            tick_sync_reg <= tick_sync_next;
        end
    end

    // ----------------------------------------
    // Speaker level controller
    // ----------------------------------------
    // Timer and limit are sampled live; changing them while powered is
    // undefined, so no shadow copies are kept.
    sac_state_t        state_reg;
    sac_state_t        state_next;
    logic [9:0]        cnt_reg;
    logic [9:0]        cnt_next;
    logic signed [7:0] gain_reg;
    logic signed [7:0] gain_next;
    logic              pwr_d_reg;
    logic              pwr_d_next;
    logic [9:0]        rec_period;
    logic [9:0]        init_len;
    logic signed [7:0] rec_max;

    always_comb begin
        rec_period = ctrl.recovery_timer_sel ? `SAC_REC_PERIOD_FS1
                                             : `SAC_REC_PERIOD_FS0;
        init_len   = ctrl.recovery_timer_sel ? `SAC_INIT_FS1
                                             : `SAC_INIT_FS0;
        rec_max    = $signed({2'b00, ctrl.recovery_gain_limit});
        pwr_d_next = ctrl.speaker_block_power_on;
        state_next = state_reg;
        cnt_next   = cnt_reg;
        gain_next  = gain_reg;
        unique case (state_reg)
            SAC_OFF: begin
                gain_next = `SAC_GAIN_FIXED;
                cnt_next  = `SAC_CNT_RESET;
                if (ctrl.speaker_block_power_on && !pwr_d_reg) begin
                    state_next = SAC_INIT;
                end
            end
            SAC_INIT: begin
                gain_next = `SAC_GAIN_FIXED;
                if (!ctrl.speaker_block_power_on) begin
                    state_next = SAC_OFF;
                end else if (fs_pulse) begin
                    if (cnt_reg == init_len - 10'h001) begin
                        state_next = SAC_RUN;
                        cnt_next   = `SAC_CNT_RESET;
                        gain_next  = `SAC_GAIN_START;
                    end else begin
                        cnt_next = cnt_reg + 10'h001;
                    end
                end
            end
            SAC_RUN: begin
                if (!ctrl.speaker_block_power_on) begin
                    state_next = SAC_OFF;
                end else if (!ctrl.speaker_level_ctrl_en) begin
                    gain_next = `SAC_GAIN_FIXED;
                    cnt_next  = `SAC_CNT_RESET;
                end else if (fs_pulse) begin
                    cnt_next = cnt_reg + 10'h001;
                    if (level.over_limit) begin
                        if (cnt_reg >= `SAC_LIM_PERIOD_FS - 10'h001) begin
                            cnt_next = `SAC_CNT_RESET;
                            if (gain_reg > `SAC_GAIN_FLOOR) begin
                                gain_next = gain_reg -
                                            `SAC_GAIN_LIM_STEP;
                            end
                        end
                    end else if (level.under_recovery) begin
                        if (level.zero_cross ||
                            cnt_reg >= rec_period - 10'h001) begin
                            cnt_next = `SAC_CNT_RESET;
                            if (gain_reg + `SAC_GAIN_REC_STEP <= rec_max)
                            begin
                                gain_next = gain_reg +
                                            `SAC_GAIN_REC_STEP;
                            end else if (gain_reg < rec_max) begin
                                gain_next = rec_max;
                            end
                        end
                    end else begin
                        cnt_next = `SAC_CNT_RESET;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SAC_OFF;
            cnt_reg   <= `SAC_CNT_RESET;
            gain_reg  <= `SAC_GAIN_FIXED;
            pwr_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            gain_reg  <= gain_next;
            pwr_d_reg <= pwr_d_next;
        end
    end

    always_comb begin
        alc_gain      = gain_reg;
        // Host watches this before leaving save mode to avoid pop noise.
        alc_init_busy = (state_reg == SAC_INIT);
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_init_hold;
        @(posedge clk) disable iff (!rst_n)
        state_reg == SAC_INIT |-> gain_reg == `SAC_GAIN_FIXED;
    endproperty
    a_init_hold: assert property (p_init_hold)
        else $error("gain not held during init");

    property p_disabled;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SAC_RUN && !ctrl.speaker_level_ctrl_en &&
         ctrl.speaker_block_power_on) |=> gain_reg == `SAC_GAIN_FIXED;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled gain not fixed");

    property p_rise_init;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SAC_OFF && ctrl.speaker_block_power_on && !pwr_d_reg)
        |=> state_reg == SAC_INIT;
    endproperty
    a_rise_init: assert property (p_rise_init)
        else $error("no init after power rise");

    property p_lim_down;
        @(posedge clk) disable iff (!rst_n)
        $past(state_reg) == SAC_RUN && state_reg == SAC_RUN &&
        gain_reg != $past(gain_reg) && $past(level.over_limit) &&
        $past(ctrl.speaker_level_ctrl_en)
        |-> gain_reg == $past(gain_reg) - `SAC_GAIN_LIM_STEP;
    endproperty
    a_lim_down: assert property (p_lim_down)
        else $error("limiter step wrong");

    property p_rec_max;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SAC_RUN && gain_reg > $past(gain_reg))
        |-> gain_reg <= rec_max;
    endproperty
    a_rec_max: assert property (p_rec_max)
        else $error("recovery beyond limit");

    property p_hold_mid;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SAC_RUN && ctrl.speaker_level_ctrl_en &&
         ctrl.speaker_block_power_on && !level.over_limit &&
         !level.under_recovery) |=> $stable(gain_reg);
    endproperty
    a_hold_mid: assert property (p_hold_mid)
        else $error("gain moved between thresholds");

    property p_spk_off;
        @(posedge clk) disable iff (!rst_n)
        !ctrl.speaker_block_power_on |-> mixer_out_oe_n &&
        speaker_pos_oe_n && speaker_neg_oe_n;
    endproperty
    a_spk_off: assert property (p_spk_off)
        else $error("speaker pins driven while off");

    property p_line_off;
        @(posedge clk) disable iff (!rst_n)
        (!ctrl.line_out_power_on && !ctrl.line_power_save)
        |-> line_pulldown_en && !line_amp_en && !dac_to_line_path;
    endproperty
    a_line_off: assert property (p_line_off)
        else $error("line not pulled low");

    property p_line_on;
        @(posedge clk) disable iff (!rst_n)
        (ctrl.line_out_power_on && !ctrl.line_power_save)
        |-> line_amp_en && !line_pulldown_en;
    endproperty
    a_line_on: assert property (p_line_on)
        else $error("line not enabled");

    property p_save_spk;
        @(posedge clk) disable iff (!rst_n)
        (ctrl.speaker_block_power_on && !ctrl.speaker_save_mode_n)
        |-> speaker_pos_oe_n && !speaker_neg_oe_n && speaker_neg_half;
    endproperty
    a_save_spk: assert property (p_save_spk)
        else $error("save mode pins wrong");

    property p_start_gain;
        @(posedge clk) disable iff (!rst_n)
        ($past(state_reg) == SAC_INIT && state_reg == SAC_RUN)
        |-> gain_reg == `SAC_GAIN_START;
    endproperty
    a_start_gain: assert property (p_start_gain)
        else $error("level control start gain wrong");

    property p_off_gain;
        @(posedge clk) disable iff (!rst_n)
        ($past(state_reg) == SAC_OFF && state_reg == SAC_OFF)
        |-> gain_reg == `SAC_GAIN_FIXED;
    endproperty
    a_off_gain: assert property (p_off_gain)
        else $error("gain not fixed while off");

    property p_init_tick;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SAC_INIT && ctrl.speaker_block_power_on && !fs_pulse)
        |=> state_reg == SAC_INIT;
    endproperty
    a_init_tick: assert property (p_init_tick)
        else $error("init ended without an fs tick");

    property p_mid_clear;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SAC_RUN && ctrl.speaker_block_power_on &&
         ctrl.speaker_level_ctrl_en && fs_pulse && !level.over_limit &&
         !level.under_recovery) |=> cnt_reg == `SAC_CNT_RESET;
    endproperty
    a_mid_clear: assert property (p_mid_clear)
        else $error("timer kept between thresholds");
endmodule // sac_output_ctrl

// >>> hdl/sac_pkg.sv
// Types shared by the speaker output control.
package sac_pkg;
    typedef struct packed {
        logic       beep_power_on;
        logic       beep_to_speaker_sel;
        logic       beep_to_line_sel;
        logic [1:0] speaker_gain_field;
        logic       dac_to_line_sw;
        logic       line_out_power_on;
        logic       line_power_save;
        logic       speaker_block_power_on;
        logic       speaker_save_mode_n;
        logic       speaker_level_ctrl_en;
        logic [5:0] recovery_gain_limit;
        logic       recovery_timer_sel;
    } sac_ctrl_t;

    typedef struct packed {
        logic over_limit;
        logic under_recovery;
        logic zero_cross;
    } sac_level_t;

    typedef enum logic [2:0] {
        SAC_OFF  = 3'b001,
        SAC_INIT = 3'b010,
        SAC_RUN  = 3'b100
    } sac_state_t;
endpackage

// >>> verif/sac_analog_model.sv
// Behavioural model of the sampling clock and level detector.
`timescale 1ns/10ps
module sac_analog_model (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic [1:0]     mode,
    output logic                fs_tick_pin,
    output sac_pkg::sac_level_t level
);
    import sac_pkg::*;
    logic [4:0] div_reg;
    // ----------------------------------------
    // Sampling clock and detector
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 5'h00;
        end else begin
            div_reg <= div_reg + 5'h01;
        end
    end
    assign fs_tick_pin = div_reg[2];
    // The crossing flag spans a whole fs period so that it is seen however
    // the design samples it.
    always_comb begin
        level.over_limit     = (mode == 2'h1);
        // Mode three is quiet with no crossings, so only timeouts step.
        level.under_recovery = (mode == 2'h2) || (mode == 2'h3);
        level.zero_cross     = (mode == 2'h2) && (div_reg[4:3] == 2'h2);
    end
endmodule // sac_analog_model

// >>> verif/sac_output_ctrl_tb.sv
// Self-checking testbench for the speaker output control.
`timescale 1ns/10ps
module sac_output_ctrl_tb;
    import sac_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [1:0]        mode = 2'h0;
    logic              fs_tick_pin;
    sac_ctrl_t         ctrl = '0;
    sac_level_t        level;
    logic              beep_stage_en, beep_to_spk_path, beep_to_line_path;
    logic [1:0]        spk_gain_sel;
    logic              dac_to_line_path, line_amp_en, line_pulldown_en;
    logic              line_soft_ramp, spk_block_en, mixer_out_oe_n;
    logic              speaker_pos_oe_n, speaker_neg_oe_n, speaker_neg_half;
    logic signed [7:0] alc_gain;
    logic              alc_init_busy;
    logic [31:0]       rnd = 32'h6ff4;
    int                err_total = 0;
    int                total_checks = 0;
    int                tick_cnt = 0;
    int                t0;
    int                i;
    logic              bad;
    // ----------------------------------------
    // Clock, partner and design
    // ----------------------------------------
    always #5 clk = ~clk;
    always @(posedge fs_tick_pin) tick_cnt++;
    sac_analog_model u_model (.clk(clk), .rst_n(rst_n), .mode(mode),
        .fs_tick_pin(fs_tick_pin), .level(level));
    sac_output_ctrl u_dut (.clk(clk), .rst_n(rst_n),
        .fs_tick_pin(fs_tick_pin), .ctrl(ctrl), .level(level),
        .beep_stage_en(beep_stage_en), .beep_to_spk_path(beep_to_spk_path),
        .beep_to_line_path(beep_to_line_path), .spk_gain_sel(spk_gain_sel),
        .dac_to_line_path(dac_to_line_path), .line_amp_en(line_amp_en),
        .line_pulldown_en(line_pulldown_en), .line_soft_ramp(line_soft_ramp),
        .spk_block_en(spk_block_en), .mixer_out_oe_n(mixer_out_oe_n),
        .speaker_pos_oe_n(speaker_pos_oe_n),
        .speaker_neg_oe_n(speaker_neg_oe_n),
        .speaker_neg_half(speaker_neg_half), .alc_gain(alc_gain),
        .alc_init_busy(alc_init_busy));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction
    task automatic chk_bit(input logic got, input logic exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic chk_gain(input logic signed [7:0] got,
                            input logic signed [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s got %0d", $time, m, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge fs_tick_pin);
        @(negedge clk);
    endtask
    task automatic init_cycle(input int lo, input int hi);
        t0 = tick_cnt;
        bad = 1'b0;
        for (i = 0; i < 8000 && alc_init_busy !== 1'b0; i++) begin
            if (alc_gain !== -8'sd7) bad = 1'b1;
            @(negedge clk);
        end
        if (i == 8000) begin
            err_total++;
            close_out();
        end
        chk_bit(bad, 1'b0, "init gain");
        chk_bit((tick_cnt - t0) inside {[lo:hi]}, 1'b1,
                "init len");
        chk_gain(alc_gain, -8'sd4, "start gain");
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        close_out();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        for (i = 0; i < 64; i++) begin
            rnd = xs(rnd);
            ctrl = sac_ctrl_t'({rnd[17:7], 7'h00});
            #1;
            chk_bit(beep_stage_en, ctrl.beep_power_on, "bp pwr");
            chk_bit(beep_to_spk_path, ctrl.beep_to_speaker_sel, "bs");
            chk_bit(beep_to_line_path, ctrl.beep_to_line_sel, "bl");
            chk_bit(spk_gain_sel == ctrl.speaker_gain_field,
                    1'b1, "gain");
            chk_bit(dac_to_line_path, ctrl.dac_to_line_sw &
                    ctrl.line_out_power_on, "dac path");
            chk_bit(line_soft_ramp, ctrl.line_power_save, "sr");
            if (!ctrl.line_power_save) begin
                chk_bit(line_pulldown_en,
                        !ctrl.line_out_power_on, "pd");
                chk_bit(line_amp_en, ctrl.line_out_power_on, "amp");
            end
            if (!ctrl.speaker_block_power_on) begin
                chk_bit(spk_block_en, 1'b0, "spk off");
                chk_bit(mixer_out_oe_n & speaker_pos_oe_n & speaker_neg_oe_n,
                        1'b1, "hiz");
            end else if (!ctrl.speaker_save_mode_n) begin
                chk_bit(speaker_pos_oe_n, 1'b1, "pos float");
                chk_bit(!speaker_neg_oe_n & speaker_neg_half,
                        1'b1, "neg");
            end else begin
                chk_bit(speaker_pos_oe_n | speaker_neg_oe_n |
                        speaker_neg_half | !spk_block_en, 1'b0, "normal");
            end
            @(negedge clk);
        end
        $display("test output map done");
        ctrl = '0;
        ticks(2);
        ctrl.line_power_save = 1'b1;
        @(negedge clk);
        ctrl.line_out_power_on = 1'b1;
        ticks(8);
        ctrl.line_power_save = 1'b0;
        #1;
        chk_bit(line_amp_en, 1'b1, "line up");
        ctrl.line_power_save = 1'b1;
        @(negedge clk);
        ctrl.line_out_power_on = 1'b0;
        ticks(8);
        ctrl.line_power_save = 1'b0;
        // Timer and limit change only while the speaker is off.
        ctrl.recovery_gain_limit = 6'h02;
        ctrl.speaker_level_ctrl_en = 1'b1;
        @(negedge clk);
        ctrl.speaker_block_power_on = 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk_bit(alc_init_busy, 1'b1, "init start");
        init_cycle(511, 514);
        ticks(40);
        chk_gain(alc_gain, -8'sd4, "hold");
        $display("test init done");
        mode = 2'h1;
        ticks(20);
        mode = 2'h0;
        chk_bit(alc_gain inside {[-15:-13]}, 1'b1, "limiter");
        mode = 2'h2;
        bad = 1'b0;
        for (i = 0; i < 200; i++) begin
            ticks(1);
            if (alc_gain > 8'sd2) bad = 1'b1;
        end
        chk_bit(bad, 1'b0, "over limit");
        chk_gain(alc_gain, 8'sd2, "recovered");
        mode = 2'h0;
        ctrl.speaker_level_ctrl_en = 1'b0;
        ticks(2);
        chk_gain(alc_gain, -8'sd7, "disabled");
        ctrl.speaker_block_power_on = 1'b0;
        ticks(2);
        chk_gain(alc_gain, -8'sd7, "power down");
        chk_bit(alc_init_busy, 1'b0, "idle");
        $display("test level control done");
        ctrl.recovery_timer_sel = 1'b1;
        ctrl.speaker_level_ctrl_en = 1'b1;
        @(negedge clk);
        ctrl.speaker_block_power_on = 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk_bit(alc_init_busy, 1'b1, "short init");
        init_cycle(255, 258);
        mode = 2'h3;
        ticks(300);
        chk_gain(alc_gain, -8'sd2, "timeout step");
        mode = 2'h0;
        rst_n = 1'b0;
        #1;
        chk_gain(alc_gain, -8'sd7, "reset gain");
        chk_bit(alc_init_busy, 1'b0, "reset idle");
        @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk_bit(alc_init_busy, 1'b1, "init after reset");
        ctrl.speaker_block_power_on = 1'b0;
        ticks(2);
        chk_bit(alc_init_busy, 1'b0, "off again");
        $display("test timer and reset done");
        close_out();
    end
endmodule // sac_output_ctrl_tb
